//--- core/pic_pkg.sv
// Package: register map, field positions and carrier types for port interrupt control
package pic_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PIC_ADDR_P0FLAG  = 8'h89;
    localparam logic [7:0] PIC_ADDR_P1FLAG  = 8'h8a;
    localparam logic [7:0] PIC_ADDR_P2FLAG  = 8'h8b;
    localparam logic [7:0] PIC_ADDR_CTRL    = 8'h8c;
    localparam logic [7:0] PIC_ADDR_P1MASK  = 8'h8d;
    localparam logic [7:0] PIC_ADDR_STATUS  = 8'h90;
    localparam logic [7:0] PIC_ADDR_IMASK   = 8'h91;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int PIC_B_DRIVE   = 6;
    localparam int PIC_B_P2EN    = 5;
    localparam int PIC_B_P0HEN   = 4;
    localparam int PIC_B_P0LEN   = 3;
    localparam int PIC_B_P2EDGE  = 2;
    localparam int PIC_B_P1EDGE  = 1;
    localparam int PIC_B_P0EDGE  = 0;
    localparam logic [7:0] PIC_CTRL_WMASK = 8'h7f;
    localparam logic [7:0] PIC_RST8       = 8'h00;
    localparam logic [4:0] PIC_RST5       = 5'h00;
    localparam logic [2:0] PIC_RST3       = 3'h0;
    localparam int PIC_P0_W     = 8;
    localparam int PIC_P1_W     = 8;
    localparam int PIC_P2_W     = 5;
    localparam int PIC_P0_HALF  = 4;
    localparam int PIC_USB_BIT  = 7;

    // Summary status bits: one per port
    localparam int PIC_S_P0 = 0;
    localparam int PIC_S_P1 = 1;
    localparam int PIC_S_P2 = 2;

    // Pin bundle
    typedef struct packed {
        logic [7:0] p0;
        logic [7:0] p1;
        logic [4:0] p2;
    } pic_pins_t;

    // Register access bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pic_bus_t;

endpackage

//--- core/pic_edge.sv
// Edge detector for one port, with selectable rising or falling edge
`timescale 1ns/100ps
module pic_edge #(
    parameter int W = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] pins_i,
    input  wire logic         falling_i,
    output logic      [W-1:0] hit_o
);
    logic [W-1:0] prev_r;

    // ------------------------------------------------------------
    // Previous pin state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_r <= '0;
        end else begin
            prev_r <= pins_i;
        end
    end

    // One-cycle hit per bit on the chosen edge
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign hit_o[g] = falling_i ? (prev_r[g] & ~pins_i[g]) : (~prev_r[g] & pins_i[g]);
        end
    endgenerate
endmodule

//--- core/pic_flags.sv
// Pending flag bank: hardware sets, software clears by writing zero
`timescale 1ns/100ps
module pic_flags #(
    parameter int W = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] flags_o
);
    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // Write 0 clears, write 1 keeps; a set in the same cycle wins
    assign flags_nxt = (wr_i ? (flags_r & wdata_i) : flags_r) | set_i;
    assign flags_o   = flags_r;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule

//--- core/pic_top.sv
// Port interrupt control: control register, edge detection, pending flags, interrupt
`timescale 1ns/100ps
module pic_top
    import pic_pkg::*;
#(
    parameter bit USB_VARIANT = 1'b0
) (
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    input  wire pic_pkg::pic_pins_t pins_i,
    input  wire logic              usb_resume_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    output logic                   drive_strength_sel_o,
    output logic      [2:0]        port_irq_req_o,
    output logic                   irq_o
);
    import pic_pkg::*;

    // Assertion clock and reset for every property below
    default clocking core_cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] port_irq_control_r;
    logic [7:0] port1_pin_irq_mask_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_status_nxt;
    logic [2:0] irq_mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_ctrl   = wr_i && (addr_i == PIC_ADDR_CTRL);
    wire wr_p1mask = wr_i && (addr_i == PIC_ADDR_P1MASK);
    wire wr_p0flag = wr_i && (addr_i == PIC_ADDR_P0FLAG);
    wire wr_p1flag = wr_i && (addr_i == PIC_ADDR_P1FLAG);
    wire wr_p2flag = wr_i && (addr_i == PIC_ADDR_P2FLAG);
    wire wr_status = wr_i && (addr_i == PIC_ADDR_STATUS);
    wire wr_imask  = wr_i && (addr_i == PIC_ADDR_IMASK);

    // Control fields
    wire drive_strength_sel = port_irq_control_r[PIC_B_DRIVE];
    wire port2_group_irq_en = port_irq_control_r[PIC_B_P2EN];
    wire port0_upper_irq_en = port_irq_control_r[PIC_B_P0HEN];
    wire port0_lower_irq_en = port_irq_control_r[PIC_B_P0LEN];
    wire port2_edge_sel     = port_irq_control_r[PIC_B_P2EDGE];
    wire port1_edge_sel     = port_irq_control_r[PIC_B_P1EDGE];
    wire port0_edge_sel     = port_irq_control_r[PIC_B_P0EDGE];

    // ------------------------------------------------------------
    // Edge detection per port
    // ------------------------------------------------------------
    logic [PIC_P0_W-1:0] p0_hit;
    logic [PIC_P1_W-1:0] p1_hit;
    logic [PIC_P2_W-1:0] p2_hit;
    logic                usb_prev_r;

    pic_edge #(.W(PIC_P0_W)) u_edge0 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (pins_i.p0),
        .falling_i  (port0_edge_sel),
        .hit_o      (p0_hit)
    );
    pic_edge #(.W(PIC_P1_W)) u_edge1 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (pins_i.p1),
        .falling_i  (port1_edge_sel),
        .hit_o      (p1_hit)
    );
    pic_edge #(.W(PIC_P2_W)) u_edge2 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (pins_i.p2),
        .falling_i  (port2_edge_sel),
        .hit_o      (p2_hit)
    );

    // USB resume rises on bit 7 of port 0; always rising, whatever the port 0 edge select
    wire       usb_hit = usb_resume_i & ~usb_prev_r;
    wire [7:0] p0_set  = USB_VARIANT ? {usb_hit, 1'b0, p0_hit[5:0]} : p0_hit;

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    logic [PIC_P0_W-1:0] port0_pending_flags;
    logic [PIC_P1_W-1:0] p1_flags;
    logic [PIC_P2_W-1:0] p2_flags;

    pic_flags #(.W(PIC_P0_W)) u_flag0 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .set_i      (p0_set),
        .wr_i       (wr_p0flag),
        .wdata_i    (wdata_i),
        .flags_o    (port0_pending_flags)
    );
    pic_flags #(.W(PIC_P1_W)) u_flag1 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .set_i      (p1_hit),
        .wr_i       (wr_p1flag),
        .wdata_i    (wdata_i),
        .flags_o    (p1_flags)
    );
    pic_flags #(.W(PIC_P2_W)) u_flag2 (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .set_i      (p2_hit),
        .wr_i       (wr_p2flag),
        .wdata_i    (wdata_i[PIC_P2_W-1:0]),
        .flags_o    (p2_flags)
    );

    // ------------------------------------------------------------
    // Per-port interrupt requests through group enables and mask
    // ------------------------------------------------------------
    wire [3:0] p0_lo = port0_pending_flags[PIC_P0_HALF-1:0];
    wire [3:0] p0_hi = port0_pending_flags[PIC_P0_W-1:PIC_P0_HALF];
    wire req_p0 = (port0_lower_irq_en & (|p0_lo))
                | (port0_upper_irq_en & (|p0_hi));
    wire req_p1 = |(p1_flags & port1_pin_irq_mask_r);
    wire req_p2 = port2_group_irq_en & (|p2_flags);
    wire [2:0] req_vec = {req_p2, req_p1, req_p0};

    // Status sticky on rising request; write one clears, set wins
    logic [2:0] req_prev_r;
    wire  [2:0] req_rise = req_vec & ~req_prev_r;
    assign irq_status_nxt = (wr_status ? (irq_status_r & ~wdata_i[2:0]) : irq_status_r)
                          | req_rise;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_irq_control_r   <= PIC_RST8;
            port1_pin_irq_mask_r <= PIC_RST8;
            irq_status_r         <= PIC_RST3;
            irq_mask_r           <= PIC_RST3;
            req_prev_r           <= PIC_RST3;
            usb_prev_r           <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                port_irq_control_r <= wdata_i & PIC_CTRL_WMASK;
            end
            if (wr_p1mask) begin
                port1_pin_irq_mask_r <= wdata_i;
            end
            if (wr_imask) begin
                irq_mask_r <= wdata_i[2:0];
            end
            irq_status_r <= irq_status_nxt;
            req_prev_r   <= req_vec;
            usb_prev_r   <= usb_resume_i;
        end
    end

    // ------------------------------------------------------------
    // Read mux, data one cycle after strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = PIC_RST8;
        case (addr_i)
            PIC_ADDR_CTRL:   rdata_nxt = port_irq_control_r;
            PIC_ADDR_P1MASK: rdata_nxt = port1_pin_irq_mask_r;
            PIC_ADDR_P0FLAG: rdata_nxt = port0_pending_flags;
            PIC_ADDR_P1FLAG: rdata_nxt = p1_flags;
            PIC_ADDR_P2FLAG: rdata_nxt = {3'h0, p2_flags};
            PIC_ADDR_STATUS: rdata_nxt = {5'h00, irq_status_r};
            PIC_ADDR_IMASK:  rdata_nxt = {5'h00, irq_mask_r};
            default:         rdata_nxt = PIC_RST8;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= PIC_RST8;
        end else begin
            rdata_r <= rd_i ? rdata_nxt : PIC_RST8;
        end
    end

    // Outputs
    assign rdata_o              = rdata_r;
    assign drive_strength_sel_o = drive_strength_sel;
    assign port_irq_req_o       = req_vec;
    assign irq_o                = |(irq_status_r & irq_mask_r);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Stimulus shapes for the write and edge properties; two-step except the one-cycle write
    sequence s_ctrl_write;
        wr_ctrl;
    endsequence

    sequence s_p1_rise;
        (!port1_edge_sel && !pins_i.p1[0]) ##1 (pins_i.p1[0] && !port1_edge_sel);
    endsequence

    sequence s_p2_fall;
        (port2_edge_sel && pins_i.p2[0]) ##1 (!pins_i.p2[0] && port2_edge_sel);
    endsequence

    sequence s_p0_rise;
        (!port0_edge_sel && !pins_i.p0[2]) ##1 (pins_i.p0[2] && !port0_edge_sel);
    endsequence

    sequence s_p0_rise_on_fall_sel;
        (port0_edge_sel && !pins_i.p0[1]) ##1 (pins_i.p0[1] && port0_edge_sel);
    endsequence

    sequence s_usb_rise;
        (USB_VARIANT && !usb_resume_i) ##1 usb_resume_i;
    endsequence

    // Control register: bit 7 clear, writes land, nothing else moves it
    a_ctrl_bit7_zero: assert property (
        port_irq_control_r[7] == 1'b0)
        else $error("control bit 7 not zero");
    a_ctrl_write_takes: assert property (
        s_ctrl_write |=> port_irq_control_r == ($past(wdata_i) & PIC_CTRL_WMASK))
        else $error("control write not stored");
    a_ctrl_hold: assert property (
        !wr_ctrl |=> $stable(port_irq_control_r))
        else $error("control changed without a write");
    a_drive_follow: assert property (
        s_ctrl_write |=> drive_strength_sel_o == $past(wdata_i[PIC_B_DRIVE]))
        else $error("drive select mismatch");

    // Group enables and the port 1 pin mask
    a_p2_gate: assert property (
        !port2_group_irq_en |-> !req_p2)
        else $error("port 2 request while disabled");
    a_p2_req_on: assert property (
        (port2_group_irq_en && (|p2_flags)) |-> req_p2)
        else $error("port 2 request missing");
    a_p0_upper_gate: assert property (
        (port0_upper_irq_en && (|p0_hi)) |-> req_p0)
        else $error("port 0 upper request missing");
    a_p0_upper_off: assert property (
        (!port0_upper_irq_en && !(port0_lower_irq_en && (|p0_lo))) |-> !req_p0)
        else $error("port 0 upper request while disabled");
    a_p0_lower_gate: assert property (
        (!port0_lower_irq_en && !port0_upper_irq_en) |-> !req_p0)
        else $error("port 0 request while disabled");
    a_p0_lower_req: assert property (
        (port0_lower_irq_en && (|p0_lo)) |-> req_p0)
        else $error("port 0 lower request missing");
    a_p1_mask_gate: assert property (
        (port1_pin_irq_mask_r == 8'h00) |-> !req_p1)
        else $error("port 1 request while masked");
    a_p1_pin_req: assert property (
        (p1_flags[0] && port1_pin_irq_mask_r[0]) |-> req_p1)
        else $error("port 1 enabled pin request missing");

    // Edge selection per port, flag visible one edge after the pin edge
    a_p1_rise_flag: assert property (
        s_p1_rise |=> p1_flags[0])
        else $error("port 1 rising edge missed");
    a_p2_fall_flag: assert property (
        s_p2_fall |=> p2_flags[0])
        else $error("port 2 falling edge missed");
    a_p0_rise_flag: assert property (
        s_p0_rise |=> port0_pending_flags[2])
        else $error("port 0 rising edge missed");
    a_p0_no_wrong: assert property (
        (s_p0_rise_on_fall_sel ##0 (!port0_pending_flags[1] && !wr_p0flag))
        |=> !port0_pending_flags[1])
        else $error("port 0 flag set on the wrong edge");

    // Pending flags: write one keeps, write zero clears
    a_flag_w1_keep: assert property (
        (wr_p1flag && wdata_i[2] && p1_flags[2]) |=> p1_flags[2])
        else $error("writing one cleared a flag");
    a_flag_w0_clear: assert property (
        (wr_p1flag && !wdata_i[3] && !p1_hit[3]) |=> !p1_flags[3])
        else $error("writing zero kept a flag");

    // Status stays until cleared; read data only after a read strobe
    a_status_sticky: assert property (
        (irq_status_r[PIC_S_P1] && !(wr_status && wdata_i[PIC_S_P1])) |=> irq_status_r[PIC_S_P1])
        else $error("status bit dropped without a clear");
    a_read_idle: assert property (
        !rd_i |=> rdata_o == PIC_RST8)
        else $error("read data without a read strobe");

    // USB variant: resume on bit 7, bit 6 never pending
    a_usb_resume: assert property (
        s_usb_rise |=> port0_pending_flags[PIC_USB_BIT])
        else $error("usb resume not flagged");
    a_usb_bit6_idle: assert property (
        USB_VARIANT |-> !port0_pending_flags[PIC_USB_BIT-1])
        else $error("unused port 0 flag set");
endmodule

//--- test/pic_pin_drv.sv
// Far-side model: external drivers on the port pins and the USB resume line
`timescale 1ns/100ps
module pic_pin_drv (
    input  wire logic               core_clk_i,
    input  wire pic_pkg::pic_pins_t pat_i,
    input  wire logic               usb_i,
    output pic_pkg::pic_pins_t      pins_o,
    output logic                    usb_resume_o
);
    import pic_pkg::*;

    // Pins and resume line follow the requested levels one cycle later
    always_ff @(posedge core_clk_i) begin
        pins_o       <= pat_i;
        usb_resume_o <= usb_i;
    end
endmodule

//--- test/port_interrupt_control_tb.sv
// Testbench: bus tasks, random pin traffic and a reference model of the block
`timescale 1ns/100ps
module port_interrupt_control_tb;
    import pic_pkg::*;

    logic            clk;
    logic            rst_n;
    logic      [7:0] addr;
    logic      [7:0] wdata;
    logic            wr;
    logic            rd;
    logic      [7:0] rdata;
    logic      [7:0] rdata2;
    logic      [7:0] wdata2;
    logic            drv;
    logic      [2:0] req;
    logic            irq;
    logic            usb;
    logic            usbp;
    logic      [7:0] lfsr_r;
    logic      [7:0] t;
    pic_pins_t       pat;
    pic_pins_t       pins;
    pic_pins_t       nv;
    int              bad_count;
    int              cmp_count;
    int              f0, f1, f2, ctrl, p1m, st, im;
    int              f0u;
    logic      [7:0] amap [8] = '{PIC_ADDR_P0FLAG, PIC_ADDR_P1FLAG, PIC_ADDR_P2FLAG,
                                  PIC_ADDR_CTRL, PIC_ADDR_P1MASK, PIC_ADDR_STATUS,
                                  PIC_ADDR_IMASK, 8'h55};

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    pic_pin_drv drv_u (
        .core_clk_i(clk), .pat_i(pat), .usb_i(usbp), .pins_o(pins), .usb_resume_o(usb)
    );

    pic_top #(.USB_VARIANT(1'b0)) dut_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .pins_i(pins), .usb_resume_i(usb),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .drive_strength_sel_o(drv), .port_irq_req_o(req), .irq_o(irq)
    );

    // USB instance: software keeps its port 0 edge select at rising
    assign wdata2 = (addr == PIC_ADDR_CTRL) ? (wdata & ~(8'h01 << PIC_B_P0EDGE)) : wdata;
    pic_top #(.USB_VARIANT(1'b1)) dut_usb_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .pins_i(pins), .usb_resume_i(usb),
        .addr_i(addr), .wdata_i(wdata2), .wr_i(wr), .rd_i(rd), .rdata_o(rdata2),
        .drive_strength_sel_o(), .port_irq_req_o(), .irq_o()
    );

    // Random source
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction

    // Model: per-port request from flags and enables
    function automatic int req_m();
        int r;
        r = 0;
        if ((ctrl[4] && (f0 & 'hf0)) || (ctrl[3] && (f0 & 'h0f))) r |= 1;
        if (f1 & p1m) r |= 2;
        if (ctrl[5] && f2) r |= 4;
        return r;
    endfunction

    // Model: register read-back
    function automatic int mdl_rd(input logic [7:0] a);
        case (a)
            PIC_ADDR_P0FLAG: return f0;
            PIC_ADDR_P1FLAG: return f1;
            PIC_ADDR_P2FLAG: return f2;
            PIC_ADDR_CTRL:   return ctrl;
            PIC_ADDR_P1MASK: return p1m;
            PIC_ADDR_STATUS: return st;
            PIC_ADDR_IMASK:  return im;
            default:         return 0;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus write, model follows
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        int r0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        r0 = req_m();
        if (a == PIC_ADDR_P0FLAG) f0u &= d;
        case (a)
            PIC_ADDR_P0FLAG: f0 &= d;
            PIC_ADDR_P1FLAG: f1 &= d;
            PIC_ADDR_P2FLAG: f2 &= d;
            PIC_ADDR_CTRL:   ctrl = d & 8'h7f;
            PIC_ADDR_P1MASK: p1m = d;
            PIC_ADDR_STATUS: st &= ~d;
            PIC_ADDR_IMASK:  im = d & 8'h07;
            default:         r0 = r0;
        endcase
        st |= req_m() & ~r0;
    endtask

    // Bus read compared with the model
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, mdl_rd(a));
        if (a == PIC_ADDR_P0FLAG) chk("usb p0 flags", rdata2, f0u[7:0]);
    endtask

    // New pin levels; model records the selected edges
    task automatic set_pins(input pic_pins_t n, input logic u);
        int r0;
        r0 = req_m();
        f0 |= ctrl[0] ? (pat.p0 & ~n.p0) : (~pat.p0 & n.p0);
        f1 |= ctrl[1] ? (pat.p1 & ~n.p1) : (~pat.p1 & n.p1);
        f2 |= ctrl[2] ? (pat.p2 & ~n.p2) : (~pat.p2 & n.p2);
        f0u |= (~pat.p0 & n.p0 & 8'h3f) | ((!usbp && u) ? 8'h80 : 8'h00);
        st |= req_m() & ~r0;
        @(posedge clk);
        pat <= n;
        usbp <= u;
        repeat (5) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        pat = '0;
        lfsr_r = 8'h33;
        bad_count = 0;
        cmp_count = 0;
        {f0, f1, f2, ctrl, p1m, st, im} = '0;
        f0u = 0;
        usbp = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (amap[i]) rd_chk(amap[i]);
        wr_reg(PIC_ADDR_CTRL, 8'hff);
        wr_reg(8'h55, 8'ha5);
        foreach (amap[i]) rd_chk(amap[i]);
        chk("drive", {7'h0, drv}, 8'h01);
        wr_reg(PIC_ADDR_IMASK, 8'h07);
        for (int k = 0; k < 32; k++) begin
            t = rnd();
            wr_reg(PIC_ADDR_CTRL, t | 8'h38);
            wr_reg(PIC_ADDR_P1MASK, rnd());
            chk("drive", {7'h0, drv}, {7'h0, t[6]});
            nv.p0 = rnd();
            nv.p1 = rnd();
            t = rnd();
            nv.p2 = t[4:0];
            set_pins(nv, t[7]);
            for (int a = 0; a < 3; a++) rd_chk(amap[a]);
            chk("req", {5'h0, req}, req_m());
            wr_reg(PIC_ADDR_CTRL, rnd());
            #1;
            chk("req", {5'h0, req}, req_m());
            rd_chk(PIC_ADDR_STATUS);
            chk("irq", {7'h0, irq}, ((st & im) != 0));
            for (int a = 0; a < 3; a++) wr_reg(amap[a], rnd());
            wr_reg(PIC_ADDR_STATUS, rnd());
            wr_reg(PIC_ADDR_IMASK, rnd());
            for (int a = 0; a < 7; a++) rd_chk(amap[a]);
            chk("irq", {7'h0, irq}, ((st & im) != 0));
        end
        complete_run();
    end
endmodule
